// [pkg/stop_ctl_pkg.sv]
// Purpose: constants and types shared by the stop-recovery and coprocessor control block
// Assumes: 100 MHz system clock, 8-bit expanded register file access
// Notes: timing figures are kept in their own units and converted to counts here
package stop_ctl_pkg;
    // register offsets in the expanded register file
    localparam logic [7:0] OFS_STOP_RECOVERY = 8'h0b;
    localparam logic [7:0] OFS_COPROC_CTRL = 8'h0c;
    localparam logic [7:0] OFS_HALF_SECOND = 8'h0d;
    localparam logic [7:0] OFS_WATCHDOG_MODE = 8'h0f;
    // stop_recovery_control fields
    localparam int SR_WARM = 7;
    localparam int SR_POL = 6;
    localparam int SR_DELAY = 5;
    localparam int SR_SRC_HI = 4;
    localparam int SR_SRC_LO = 2;
    localparam int SR_DIV16 = 0;
    localparam logic [6:0] SR_RESET = 7'h20;
    // coprocessor_control fields
    localparam int CC_DIV_HI = 7;
    localparam int CC_DIV_LO = 6;
    localparam int CC_RESET = 5;
    localparam int CC_RUN = 4;
    localparam int CC_INT2 = 1;
    localparam int CC_IRQ3 = 0;
    localparam logic [1:0] CC_DIV_RESET = 2'h0;
    // watchdog_mode fields, then the half-second flag
    localparam int WM_CLKSEL = 4;
    localparam int WM_STOP = 3;
    localparam int WM_PER_HI = 1;
    localparam int WM_PER_LO = 0;
    localparam logic [7:0] WM_RESET = 8'h0c;
    localparam int HS_FLAG = 0;
    // wake source selections
    typedef enum logic [2:0] {
        WS_RESET_ONLY = 3'b000, WS_NONE = 3'b001, WS_PORT3_1 = 3'b010, WS_PORT3_2 = 3'b011,
        WS_PORT3_3 = 3'b100, WS_HALF_SEC = 3'b101, WS_NOR4 = 3'b110, WS_NOR8 = 3'b111
    } wake_src_t;
    typedef enum logic [1:0] {PS_POR = 2'b00, PS_RUN = 2'b01, PS_STOP = 2'b10} pwr_state_t;
    // timing
    localparam int CLK_MHZ = 100;
    localparam int POR_TIME_US = 5000;
    localparam int POR_W = 20;
    localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
    localparam logic [6:0] ACCESS_WINDOW = 7'h40;
    localparam int PRESCALE_W = 4;
    localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = 4'hf;
    localparam int RTC_HZ = 32768;
    localparam int HS_W = 14;
    localparam logic [HS_W-1:0] HS_LAST = HS_W'(RTC_HZ / 2 - 1);
    // watchdog periods: crystal periods, or rc milliseconds times an assumed rc rate
    localparam int WDT_W = 16;
    localparam int RC_TICKS_PER_MS = 32;
    localparam logic [WDT_W-1:0] WDT_XTAL_0 = 16'h0100;
    localparam logic [WDT_W-1:0] WDT_XTAL_1 = 16'h0200;
    localparam logic [WDT_W-1:0] WDT_XTAL_2 = 16'h0400;
    localparam logic [WDT_W-1:0] WDT_XTAL_3 = 16'h1000;
    localparam logic [WDT_W-1:0] WDT_RC_0 = WDT_W'(5 * RC_TICKS_PER_MS);
    localparam logic [WDT_W-1:0] WDT_RC_1 = WDT_W'(15 * RC_TICKS_PER_MS);
    localparam logic [WDT_W-1:0] WDT_RC_2 = WDT_W'(25 * RC_TICKS_PER_MS);
    localparam logic [WDT_W-1:0] WDT_RC_3 = WDT_W'(100 * RC_TICKS_PER_MS);

    function automatic logic [WDT_W-1:0] wdt_limit(input logic [1:0] sel, input logic rc);
        logic [WDT_W-1:0] x;
        logic [WDT_W-1:0] r;
        unique case (sel)
            2'b00: begin x = WDT_XTAL_0; r = WDT_RC_0; end
            2'b01: begin x = WDT_XTAL_1; r = WDT_RC_1; end
            2'b10: begin x = WDT_XTAL_2; r = WDT_RC_2; end
            2'b11: begin x = WDT_XTAL_3; r = WDT_RC_3; end
        endcase
        return rc ? r : x;
    endfunction
endpackage

// [sim/coproc_model.sv]
// Purpose: behavioural coprocessor at the far side of the control block
// Assumes: one clock, synchronous active-low reset
// Notes: halts whenever its clock gate is low; acks interrupt two only when allowed
`timescale 1ns/1ps
module coproc_model (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic run_in,
    input wire logic int2_in,
    input wire logic reset_in,
    input wire logic ack_en_in,
    input wire logic irq_req_in,
    output logic halted_out,
    output logic irq3_set_out,
    output logic int2_ack_out
);
    logic [1:0] wait_ff;
    // halt state is not cleared by a coprocessor reset, else reset pulses would loop
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            halted_out <= 1'b0;
            irq3_set_out <= 1'b0;
            int2_ack_out <= 1'b0;
            wait_ff <= 2'h0;
        end else begin
            halted_out <= !run_in;
            irq3_set_out <= irq_req_in;
            int2_ack_out <= 1'b0;
            if (reset_in) begin
                wait_ff <= 2'h0;
            end else if (int2_in && ack_en_in && !int2_ack_out) begin
                wait_ff <= wait_ff + 2'h1;
                if (wait_ff == 2'h3) begin
                    int2_ack_out <= 1'b1;
                end
            end
        end
    end
endmodule // coproc_model

// [sim/testbench.sv]
// Purpose: self-checking bench for the stop-recovery and coprocessor control block
// Assumes: power-on delay shortened to 20 cycles, crystal tick every cycle
// Notes: half-second checks run the real 16384-tick count
`timescale 1ns/1ps
module testbench;
    import stop_ctl_pkg::*;
    typedef struct {logic [7:0] wd; logic [7:0] rd; logic [1:0] dv; logic run;} row_t;
    row_t rows [4] = '{'{8'h50, 8'h50, 2'h1, 1'b1}, '{8'h8c, 8'h80, 2'h2, 1'b0},
        '{8'hd0, 8'hd0, 2'h3, 1'b1}, '{8'h12, 8'h12, 2'h0, 1'b1}};
    logic clk, rstn, wr, rd, stp, kick, rtc, ack_en, irq_req, halted, irq3, ack;
    logic [7:0] addr, wdata, rdata, port2, d;
    logic [3:0] port3;
    logic hrst, smode, sen, ten, crst, run, int2, hirq;
    logic [1:0] dv;
    int n_errors = 0;
    int cmp_count = 0;
    int i, ns, nt;

    stop_recovery_ctrl #(.POR_CYCLES_P(20'h14)) u_stop_recovery_ctrl (.CLK_SYS_IN(clk), .RESETN_IN(rstn),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .STOP_ENTER_IN(stp),
        .WATCHDOG_KICK_IN(kick), .PORT3_IN(port3), .PORT2_IN(port2), .RTC_TICK_IN(rtc), .CRYSTAL_TICK_IN(1'b1),
        .RC_TICK_IN(1'b0), .COPROC_HALTED_IN(halted), .COPROC_IRQ3_SET_IN(irq3), .COPROC_INT2_ACK_IN(ack),
        .REG_RDATA_OUT(rdata), .HOST_RESET_OUT(hrst), .STOP_MODE_OUT(smode), .SYS_CLK_EN_OUT(sen),
        .TIMER_CLK_EN_OUT(ten), .HOST_CLOCK_DIVIDE_OUT(dv), .COPROC_RESET_OUT(crst), .COPROC_RUN_OUT(run),
        .COPROC_INT2_OUT(int2), .HOST_IRQ3_OUT(hirq));
    coproc_model u_coproc_model (.clk_in(clk), .resetn_in(rstn), .run_in(run), .int2_in(int2), .reset_in(crst),
        .ack_en_in(ack_en), .irq_req_in(irq_req), .halted_out(halted), .irq3_set_out(irq3), .int2_ack_out(ack));

    // free-running system clock
    always #5 clk = ~clk;

    task automatic test_done();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // strobe held one cycle; taken at the second edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    // bounded wait on host reset (0), stop mode (1) or coprocessor reset (2)
    task automatic wait_for(input int s, input logic v, input int n);
        logic x;
        for (int k = 0; k < n; k++) begin
            x = (s == 0) ? hrst : (s == 1) ? smode : crst;
            if (x === v) break;
            @(posedge clk);
            #1;
        end
        chk({7'h0, x}, {7'h0, v});
        if (x !== v) test_done();
    endtask

    task automatic stop_pulse();
        @(posedge clk);
        stp <= 1'b1;
        @(posedge clk);
        stp <= 1'b0;
        #1;
    endtask

    task automatic count_en(input int n);
        ns = 0;
        nt = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            ns += sen;
            nt += ten;
        end
    endtask

    initial begin
        clk = 0; rstn = 0; wr = 0; rd = 0; stp = 0; kick = 0; rtc = 0; ack_en = 0; irq_req = 0;
        addr = 8'h00; wdata = 8'h00; port2 = 8'hff; port3 = 4'h0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(OFS_WATCHDOG_MODE, d); chk(d, 8'h0c);
        wr_reg(OFS_WATCHDOG_MODE, 8'h1c);
        rd_reg(OFS_WATCHDOG_MODE, d); chk(d, 8'h1c);
        chk({7'h0, hrst}, 8'h01);
        wait_for(0, 1'b0, 40);
        repeat (64) @(posedge clk);
        rd_reg(OFS_WATCHDOG_MODE, d); chk(d, 8'h00);
        rd_reg(8'h0e, d); chk(d, 8'h00);
        rd_reg(OFS_STOP_RECOVERY, d); chk(d, 8'h00);
        // control register field table
        for (i = 0; i < 4; i++) begin
            wr_reg(OFS_COPROC_CTRL, rows[i].wd);
            rd_reg(OFS_COPROC_CTRL, d); chk(d, rows[i].rd);
            chk({6'h0, dv}, {6'h0, rows[i].dv});
            chk({7'h0, run}, {7'h0, rows[i].run});
        end
        chk({7'h0, int2}, 8'h01);
        ack_en <= 1'b1;
        repeat (8) @(posedge clk);
        #1 chk({7'h0, int2}, 8'h00);
        rd_reg(OFS_COPROC_CTRL, d); chk(d, 8'h10);
        @(posedge clk) irq_req <= 1'b1;
        @(posedge clk) irq_req <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk({7'h0, hirq}, 8'h01);
        rd_reg(OFS_COPROC_CTRL, d); chk(d, 8'h11);
        wr_reg(OFS_COPROC_CTRL, 8'h11);
        @(posedge clk);
        #1 chk({7'h0, hirq}, 8'h00);
        wr_reg(OFS_COPROC_CTRL, 8'h30); chk({7'h0, crst}, 8'h01);
        @(posedge clk);
        #1 chk({7'h0, crst}, 8'h00);
        rd_reg(OFS_COPROC_CTRL, d); chk(d, 8'h10);
        wr_reg(OFS_COPROC_CTRL, 8'h00);
        wait_for(2, 1'b1, 8);
        wr_reg(OFS_COPROC_CTRL, 8'h10);
        // prescaler on then off
        wr_reg(OFS_STOP_RECOVERY, 8'h21);
        count_en(16);
        count_en(64); chk(8'(ns), 8'h04); chk(8'(nt), 8'h04);
        wr_reg(OFS_STOP_RECOVERY, 8'h20);
        count_en(4);
        count_en(16); chk(8'(ns), 8'h10); chk(8'(nt), 8'h10);
        // fast wake on high level of port-3 line 1
        wr_reg(OFS_STOP_RECOVERY, 8'h48);
        stop_pulse(); chk({7'h0, smode}, 8'h01);
        rd_reg(OFS_STOP_RECOVERY, d); chk(d, 8'h80);
        port3 <= 4'h2;
        wait_for(1, 1'b0, 8);
        chk({7'h0, hrst}, 8'h00);
        repeat (6) @(posedge clk);
        port3 <= 4'h0;
        // delayed wake on nor of low port-2 nibble
        port2 <= 8'h01;
        wr_reg(OFS_STOP_RECOVERY, 8'h78);
        stop_pulse();
        port2 <= 8'h00;
        wait_for(1, 1'b0, 8);
        @(posedge clk);
        #1 chk({7'h0, hrst}, 8'h01);
        wait_for(0, 1'b0, 40);
        port2 <= 8'hff;
        // watchdog on crystal ticks: 256 period, restarted once
        @(posedge clk) kick <= 1'b1;
        @(posedge clk) kick <= 1'b0;
        repeat (200) @(posedge clk);
        #1 chk({7'h0, hrst}, 8'h00);
        @(posedge clk) kick <= 1'b1;
        @(posedge clk) kick <= 1'b0;
        repeat (200) @(posedge clk);
        #1 chk({7'h0, hrst}, 8'h00);
        wait_for(0, 1'b1, 80);
        wait_for(0, 1'b0, 40);
        rd_reg(OFS_STOP_RECOVERY, d); chk({d[7], 7'h0}, 8'h00);
        // half-second flag and wake
        wr_reg(OFS_HALF_SECOND, 8'h00);
        rtc <= 1'b1;
        repeat (16000) @(posedge clk);
        rd_reg(OFS_HALF_SECOND, d); chk({7'h0, d[0]}, 8'h00);
        repeat (400) @(posedge clk);
        rd_reg(OFS_HALF_SECOND, d); chk({7'h0, d[0]}, 8'h01);
        wr_reg(OFS_HALF_SECOND, 8'h00);
        rd_reg(OFS_HALF_SECOND, d); chk({7'h0, d[0]}, 8'h00);
        wr_reg(OFS_STOP_RECOVERY, 8'h14);
        stop_pulse();
        wait_for(1, 1'b0, 17000);
        rd_reg(OFS_HALF_SECOND, d); chk({7'h0, d[0]}, 8'h01);
        // reset-only source never wakes; the mid-run reset ends this stop
        wr_reg(OFS_STOP_RECOVERY, 8'h00);
        stop_pulse();
        repeat (8) @(posedge clk);
        #1 chk({7'h0, smode}, 8'h01);
        @(posedge clk) rstn <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk({7'h0, hrst}, 8'h01);
        chk({7'h0, smode}, 8'h00);
        @(posedge clk) rstn <= 1'b1;
        rd_reg(OFS_COPROC_CTRL, d); chk(d, 8'h10);
        rd_reg(OFS_STOP_RECOVERY, d); chk(d, 8'h00);
        test_done();
    end
endmodule // testbench

// [src/oneshot_counter.sv]
// Purpose: retriggerable one-shot counting enabled ticks up to a limit
// Assumes: start and tick are synchronous single-cycle qualifiers
// Notes: start restarts the count from zero even while busy
`timescale 1ns/1ps
module oneshot_counter #(
    parameter int W = 16
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic start_in,
    input wire logic tick_in,
    input wire logic [W-1:0] limit_in,
    output logic busy_out,
    output logic done_out
);
    logic [W-1:0] cnt_ff, nxt_cnt;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;

    // terminal count gives a one-cycle done pulse
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        if (start_in) begin
            nxt_cnt = '0;
            nxt_busy = 1'b1;
        end else if (busy_ff && tick_in) begin
            if (cnt_ff == limit_in - W'(1)) begin
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + W'(1);
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            cnt_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
        end
    end

    assign busy_out = busy_ff;
    assign done_out = done_ff;
endmodule // oneshot_counter

// [src/prescale_tick.sv]
// Purpose: clock-enable tick, every cycle or every sixteenth cycle
// Assumes: one system clock, synchronous active-low reset
// Notes: tick is registered so callers see a clean enable
`timescale 1ns/1ps
module prescale_tick (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic div16_in,
    output logic tick_out
);
    import stop_ctl_pkg::*;
    logic [PRESCALE_W-1:0] cnt_ff, nxt_cnt;
    logic tick_ff, nxt_tick;

    // free-running count keeps the divided phase stable across mode changes
    always_comb begin
        nxt_cnt = cnt_ff + PRESCALE_W'(1);
        nxt_tick = !div16_in || (cnt_ff == PRESCALE_LAST);
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick_out = tick_ff;
endmodule // prescale_tick

// [src/stop_recovery_ctrl.sv]
// Purpose: stop-mode recovery, prescaler, coprocessor control, watchdog and half-second timer
// Assumes: all inputs synchronous to CLK_SYS_IN; ticks are one-cycle enables
// Notes: register reads answer one cycle after the read strobe
// Function
// - recovery register write-only, bit 7 read-only
// - warm flag set on stop, cleared on reset
// - bit 6 picks wake level polarity
// - bit 5 low skips wake reset delay
// - bits 4-2 select the wake source
// - bit 0 divides system/timer clock by 16
// - control bits 7-6 set host clock divide
// - write 1 resets coprocessor, reads zero
// - halted coprocessor presets reset control
// - bit 4 gates coprocessor clock, resets to 1
// - write 1 raises coprocessor interrupt two
// - bit 0 shows/clears host interrupt three
// - watchdog terminal count resets host
// - first kick enables, later kicks restart
// - watchdog mode bit 4 selects clock source
// - watchdog mode reachable first 64 cycles only
// - half-second timeout sets status bit 0
// - half-second timeout ends stop when selected
// - period bits pick watchdog timeout length
// - power-on one-shot from power, watchdog, delayed wake
`timescale 1ns/1ps
module stop_recovery_ctrl #(
    parameter logic [stop_ctl_pkg::POR_W-1:0] POR_CYCLES_P = stop_ctl_pkg::POR_W'(stop_ctl_pkg::POR_CYCLES)
) (
    input wire logic CLK_SYS_IN,
    input wire logic RESETN_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic STOP_ENTER_IN,
    input wire logic WATCHDOG_KICK_IN,
    input wire logic [3:0] PORT3_IN,
    input wire logic [7:0] PORT2_IN,
    input wire logic RTC_TICK_IN,
    input wire logic CRYSTAL_TICK_IN,
    input wire logic RC_TICK_IN,
    input wire logic COPROC_HALTED_IN,
    input wire logic COPROC_IRQ3_SET_IN,
    input wire logic COPROC_INT2_ACK_IN,
    output logic [7:0] REG_RDATA_OUT,
    output logic HOST_RESET_OUT,
    output logic STOP_MODE_OUT,
    output logic SYS_CLK_EN_OUT,
    output logic TIMER_CLK_EN_OUT,
    output logic [1:0] HOST_CLOCK_DIVIDE_OUT,
    output logic COPROC_RESET_OUT,
    output logic COPROC_RUN_OUT,
    output logic COPROC_INT2_OUT,
    output logic HOST_IRQ3_OUT
);
    import stop_ctl_pkg::*;

    pwr_state_t state_ff, nxt_state;
    logic [6:0] sr_ff, nxt_sr;
    logic warm_ff, nxt_warm;
    logic kick_ff, nxt_kick;
    logic host_rst_ff, nxt_host_rst;
    logic stop_ff, nxt_stop;
    logic [1:0] div_ff, nxt_div;
    logic run_ff, nxt_run;
    logic int2_ff, nxt_int2;
    logic irq3_ff, nxt_irq3;
    logic creset_ff, nxt_creset;
    logic halted_q_ff;
    logic [7:0] wm_ff, nxt_wm;
    logic [6:0] acc_cnt_ff, nxt_acc_cnt;
    logic wdt_en_ff, nxt_wdt_en;
    logic hs_ff, nxt_hs;
    logic [HS_W-1:0] hs_cnt_ff, nxt_hs_cnt;
    logic [7:0] rdata_ff, nxt_rdata;
    logic wr_sr, wr_cc, wr_hs, wr_wm, wm_open;
    logic half_done, wake, src_level;
    logic por_done, wdt_done, wdt_tick, src_tick;
    logic presc_tick;

    // register write decode
    assign wr_sr = REG_WR_IN && (REG_ADDR_IN == OFS_STOP_RECOVERY);
    assign wr_cc = REG_WR_IN && (REG_ADDR_IN == OFS_COPROC_CTRL);
    assign wr_hs = REG_WR_IN && (REG_ADDR_IN == OFS_HALF_SECOND);
    assign wr_wm = REG_WR_IN && (REG_ADDR_IN == OFS_WATCHDOG_MODE);
    assign wm_open = acc_cnt_ff < ACCESS_WINDOW;

    // wake source and level check; fast wake trusts the source to be held long enough
    always_comb begin
        src_level = 1'b0;
        wake = 1'b0;
        unique case (wake_src_t'(sr_ff[SR_SRC_HI:SR_SRC_LO]))
            WS_PORT3_1: src_level = PORT3_IN[1];
            WS_PORT3_2: src_level = PORT3_IN[2];
            WS_PORT3_3: src_level = PORT3_IN[3];
            WS_NOR4: src_level = ~|PORT2_IN[3:0];
            WS_NOR8: src_level = ~|PORT2_IN;
            WS_HALF_SEC: wake = half_done;
            WS_RESET_ONLY, WS_NONE: src_level = 1'b0;
        endcase
        if (sr_ff[SR_SRC_HI:SR_SRC_LO] inside {WS_PORT3_1, WS_PORT3_2, WS_PORT3_3, WS_NOR4, WS_NOR8}) begin
            wake = (src_level == sr_ff[SR_POL]);
        end
    end

    // power state: power-on delay, running, stopped
    always_comb begin
        nxt_state = state_ff;
        nxt_warm = warm_ff;
        nxt_kick = 1'b0;
        unique case (state_ff)
            PS_POR: if (por_done) nxt_state = PS_RUN;
            PS_RUN: begin
                if (STOP_ENTER_IN) begin
                    nxt_state = PS_STOP;
                    nxt_warm = 1'b1;
                end
            end
            PS_STOP: begin
                if (wake && sr_ff[SR_DELAY]) begin
                    nxt_state = PS_POR;
                    nxt_kick = 1'b1;
                end else if (wake) begin
                    nxt_state = PS_RUN;
                end
            end
            default: begin
                nxt_state = PS_POR;
                nxt_kick = 1'b1;
            end
        endcase
        // watchdog timeout overrides everything and counts as a cold start
        if (wdt_done) begin
            nxt_state = PS_POR;
            nxt_kick = 1'b1;
            nxt_warm = 1'b0;
        end
        nxt_host_rst = (nxt_state == PS_POR);
        nxt_stop = (nxt_state == PS_STOP);
    end

    // recovery, coprocessor and half-second registers; hardware set beats software clear
    always_comb begin
        nxt_sr = wr_sr ? REG_WDATA_IN[6:0] : sr_ff;
        nxt_div = wr_cc ? REG_WDATA_IN[CC_DIV_HI:CC_DIV_LO] : div_ff;
        nxt_run = wr_cc ? REG_WDATA_IN[CC_RUN] : run_ff;
        nxt_creset = (wr_cc && REG_WDATA_IN[CC_RESET]) || (COPROC_HALTED_IN && !halted_q_ff);
        nxt_int2 = (wr_cc && REG_WDATA_IN[CC_INT2]) || (int2_ff && !COPROC_INT2_ACK_IN);
        nxt_irq3 = COPROC_IRQ3_SET_IN || (irq3_ff && !(wr_cc && REG_WDATA_IN[CC_IRQ3]));
        nxt_hs = half_done || (hs_ff && !(wr_hs && !REG_WDATA_IN[HS_FLAG]));
        nxt_hs_cnt = hs_cnt_ff;
        if (RTC_TICK_IN) begin
            nxt_hs_cnt = (hs_cnt_ff == HS_LAST) ? '0 : hs_cnt_ff + HS_W'(1);
        end
    end
    assign half_done = RTC_TICK_IN && (hs_cnt_ff == HS_LAST);

    // watchdog: mode register only inside the post-reset window
    always_comb begin
        nxt_wm = (wr_wm && wm_open) ? REG_WDATA_IN : wm_ff;
        nxt_acc_cnt = wm_open ? acc_cnt_ff + 7'h01 : acc_cnt_ff;
        nxt_wdt_en = WATCHDOG_KICK_IN || (wdt_en_ff && !wdt_done);
    end
    assign src_tick = wm_ff[WM_CLKSEL] ? CRYSTAL_TICK_IN : RC_TICK_IN;
    // the crystal stops in stop mode, so counting there needs the stop-enable bit
    assign wdt_tick = wdt_en_ff && src_tick && (!stop_ff || wm_ff[WM_STOP]);

    // registered read answer; unmapped and closed addresses read zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (REG_RD_IN) begin
            unique case (REG_ADDR_IN)
                OFS_STOP_RECOVERY: nxt_rdata = {warm_ff, 7'h00};
                OFS_COPROC_CTRL: nxt_rdata = {div_ff, 1'b0, run_ff, 2'b00, int2_ff, irq3_ff};
                OFS_HALF_SECOND: nxt_rdata = {7'h00, hs_ff};
                OFS_WATCHDOG_MODE: nxt_rdata = wm_open ? wm_ff : 8'h00;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RESETN_IN) begin
            state_ff <= PS_POR;
            warm_ff <= 1'b0;
            kick_ff <= 1'b1;
            host_rst_ff <= 1'b1;
            stop_ff <= 1'b0;
            sr_ff <= SR_RESET;
            div_ff <= CC_DIV_RESET;
            run_ff <= 1'b1;
            int2_ff <= 1'b0;
            irq3_ff <= 1'b0;
            creset_ff <= 1'b0;
            halted_q_ff <= 1'b0;
            wm_ff <= WM_RESET;
            acc_cnt_ff <= 7'h00;
            wdt_en_ff <= 1'b0;
            hs_ff <= 1'b0;
            hs_cnt_ff <= '0;
            rdata_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            warm_ff <= nxt_warm;
            kick_ff <= nxt_kick;
            host_rst_ff <= nxt_host_rst;
            stop_ff <= nxt_stop;
            sr_ff <= nxt_sr;
            div_ff <= nxt_div;
            run_ff <= nxt_run;
            int2_ff <= nxt_int2;
            irq3_ff <= nxt_irq3;
            creset_ff <= nxt_creset;
            halted_q_ff <= COPROC_HALTED_IN;
            wm_ff <= nxt_wm;
            acc_cnt_ff <= nxt_acc_cnt;
            wdt_en_ff <= nxt_wdt_en;
            hs_ff <= nxt_hs;
            hs_cnt_ff <= nxt_hs_cnt;
            rdata_ff <= nxt_rdata;
        end
    end

    // power-on one-shot counts system cycles
    oneshot_counter #(.W(POR_W)) u_por (
        .clk_in(CLK_SYS_IN),
        .resetn_in(RESETN_IN),
        .start_in(kick_ff),
        .tick_in(1'b1),
        .limit_in(POR_CYCLES_P),
        .busy_out(),
        .done_out(por_done)
    );

    // watchdog one-shot, restarted by every kick
    oneshot_counter #(.W(WDT_W)) u_wdt (
        .clk_in(CLK_SYS_IN),
        .resetn_in(RESETN_IN),
        .start_in(WATCHDOG_KICK_IN),
        .tick_in(wdt_tick),
        .limit_in(wdt_limit(wm_ff[WM_PER_HI:WM_PER_LO], !wm_ff[WM_CLKSEL])),
        .busy_out(),
        .done_out(wdt_done)
    );

    prescale_tick u_presc (
        .clk_in(CLK_SYS_IN),
        .resetn_in(RESETN_IN),
        .div16_in(sr_ff[SR_DIV16]),
        .tick_out(presc_tick)
    );

    assign REG_RDATA_OUT = rdata_ff;
    assign HOST_RESET_OUT = host_rst_ff;
    assign STOP_MODE_OUT = stop_ff;
    assign SYS_CLK_EN_OUT = presc_tick;
    assign TIMER_CLK_EN_OUT = presc_tick;
    assign HOST_CLOCK_DIVIDE_OUT = div_ff;
    assign COPROC_RESET_OUT = creset_ff;
    assign COPROC_RUN_OUT = run_ff;
    assign COPROC_INT2_OUT = int2_ff;
    assign HOST_IRQ3_OUT = irq3_ff;

    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RESETN_IN);

    sequence s_enter_stop;
        (state_ff == PS_RUN) && STOP_ENTER_IN && !wdt_done;
    endsequence
    property p_warm_set;
        s_enter_stop |=> warm_ff && STOP_MODE_OUT;
    endproperty
    a_warm_set: assert property (p_warm_set) else $error("warm flag not set on stop");
    property p_sr_read;
        REG_RD_IN && (REG_ADDR_IN == OFS_STOP_RECOVERY) |=> REG_RDATA_OUT == {$past(warm_ff), 7'h00};
    endproperty
    a_sr_read: assert property (p_sr_read) else $error("recovery read shows more than bit 7");
    property p_fast_wake;
        (state_ff == PS_STOP) && wake && !sr_ff[SR_DELAY] && !wdt_done |=> !STOP_MODE_OUT && !HOST_RESET_OUT;
    endproperty
    a_fast_wake: assert property (p_fast_wake) else $error("fast wake held reset");
    property p_p31_wake;
        (state_ff == PS_STOP) && (sr_ff[SR_SRC_HI:SR_SRC_LO] == WS_PORT3_1) && (PORT3_IN[1] == sr_ff[SR_POL])
            |=> !STOP_MODE_OUT;
    endproperty
    a_p31_wake: assert property (p_p31_wake) else $error("port wake missed");
    property p_no_div;
        RESETN_IN && !sr_ff[SR_DIV16] |=> SYS_CLK_EN_OUT; // release edge still holds the reset tick
    endproperty
    a_no_div: assert property (p_no_div) else $error("undivided clock enable dropped");
    property p_cc_write;
        wr_cc |=> HOST_CLOCK_DIVIDE_OUT == $past(REG_WDATA_IN[CC_DIV_HI:CC_DIV_LO])
            && COPROC_RUN_OUT == $past(REG_WDATA_IN[CC_RUN]);
    endproperty
    a_cc_write: assert property (p_cc_write) else $error("control write not applied");
    property p_creset;
        wr_cc && REG_WDATA_IN[CC_RESET] |=> COPROC_RESET_OUT;
    endproperty
    a_creset: assert property (p_creset) else $error("coprocessor reset not raised");
    property p_int2;
        wr_cc && REG_WDATA_IN[CC_INT2] |=> COPROC_INT2_OUT;
    endproperty
    a_int2: assert property (p_int2) else $error("interrupt two not raised");
    property p_irq3;
        COPROC_IRQ3_SET_IN |=> HOST_IRQ3_OUT;
    endproperty
    a_irq3: assert property (p_irq3) else $error("host interrupt three lost");
    property p_wm_closed;
        !wm_open |=> $stable(wm_ff);
    endproperty
    a_wm_closed: assert property (p_wm_closed) else $error("watchdog mode changed after window");
    property p_wdt_reset;
        wdt_done |=> HOST_RESET_OUT && !warm_ff;
    endproperty
    a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog timeout did not reset");
    property p_hs_set;
        half_done |=> hs_ff;
    endproperty
    a_hs_set: assert property (p_hs_set) else $error("half-second flag not set");
endmodule // stop_recovery_ctrl
